//--- hw/timer16_regs.vh
// Register offsets, fields and constants of the 16-bit pulse/capture timer
`ifndef TIMER16_REGS_VH
`define TIMER16_REGS_VH
`define OFF_CTRL 12'h000
`define OFF_CCA 12'h004
`define OFF_CCB 12'h008
`define OFF_COUNT 12'h00C
`define OFF_STATUS 12'h010
`define OFF_TRIG 12'h014
`define CTRL_MODE_LO 0
`define CTRL_MODE_HI 1
`define CTRL_FUNC_LO 2
`define CTRL_FUNC_HI 3
`define CTRL_CAPSEL 4
`define CTRL_EDGE_LO 5
`define CTRL_EDGE_HI 6
`define CTRL_EDGEB_LO 7
`define CTRL_EDGEB_HI 8
`define CTRL_WIDTH 9
`define CTRL_RESET 9'h000
`define MODE_STOP 2'h0
`define MODE_FREE 2'h1
`define MODE_CLR_EDGE 2'h2
`define MODE_CLR_MATCH 2'h3
`define FUNC_CAPTURE 2'h0
`define FUNC_PPG 2'h1
`define FUNC_ONESHOT 2'h2
`define FUNC_EVENT 2'h3
`define EDGE_FALL 2'h0
`define EDGE_RISE 2'h1
`define EDGE_NONE 2'h2
`define EDGE_BOTH 2'h3
`define CC_RESET 16'hFFFF
`define PRESCALE 4'h3
`endif

//--- hw/timer16_pulse_capture.v
// 16-bit timer/event counter with two capture/compare registers on APB
// What this block does and what it expects of software and the outside driver
// RL1 - Pulse mode period is reg_a+1 count clocks with active part reg_b+1 count clocks.
// RL2 - Software keeps 0 < reg_b < reg_a <= FFFF in pulse mode.
// RL3 - Software does not retrigger the one-shot while its pulse is active.
// RL4 - In soft-trigger one-shot, a valid edge on input a still restarts and fires a pulse.
// RL5 - Software never loads zero into either compare register for one-shot use.
// RL6 - Mode 00 means stopped and any nonzero mode starts counting at once.
// RL7 - The outside driver gives no new trigger edge while a one-shot pulse is active.
// RL8 - The first match after start may be one count clock early or late.
// RL9 - One-shot works only in free-running or clear-on-edge mode, never clear-on-match.
// RL10 - With capture select 1 and both edges on input a, reg_a does not capture.
// RL11 - With capture select 1, an edge on input b skips capture into reg_a but raises irq a.
// RL12 - Software rewrites compare registers only from the match service.
// RL13 - In pulse mode, a rewrite of reg_b while counting toggles the output pin at each rewrite.
// RL14 - Event counting begins only after two valid edges following start.
`timescale 1ns/100ps
`default_nettype none
`include "timer16_regs.vh"
module timer16_pulse_capture (
   input wire clock,
   input wire rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire trigger_capture_input_a,
   input wire capture_input_b,
   output reg timer_output_pin,
   output reg match_capture_irq_a,
   output reg match_irq_b
);
   reg [8:0] ctrl_reg;
   reg [15:0] compare_capture_reg_a;
   reg [15:0] compare_capture_reg_b;
   reg [15:0] timer_count_value;
   reg [1:0] sync_a_reg;
   reg [1:0] sync_b_reg;
   reg in_a_reg;
   reg in_b_reg;
   reg [3:0] presc_reg;
   reg oneshot_active_reg;
   reg [1:0] event_edges_reg;
   reg ovf_flag_reg;
   reg soft_trig_reg;
   wire [1:0] op_mode = ctrl_reg[`CTRL_MODE_HI:`CTRL_MODE_LO];
   wire [1:0] func = ctrl_reg[`CTRL_FUNC_HI:`CTRL_FUNC_LO];
   wire capture_source_select = ctrl_reg[`CTRL_CAPSEL];
   wire [1:0] edge_a = ctrl_reg[`CTRL_EDGE_HI:`CTRL_EDGE_LO];
   wire [1:0] edge_b = ctrl_reg[`CTRL_EDGEB_HI:`CTRL_EDGEB_LO];
   wire a_rise = sync_a_reg[1] & ~in_a_reg;
   wire a_fall = ~sync_a_reg[1] & in_a_reg;
   wire b_rise = sync_b_reg[1] & ~in_b_reg;
   wire b_fall = ~sync_b_reg[1] & in_b_reg;
   wire a_valid = (edge_a == `EDGE_RISE & a_rise) | (edge_a == `EDGE_FALL & a_fall) |
      (edge_a == `EDGE_BOTH & (a_rise | a_fall));
   wire b_valid = (edge_b == `EDGE_RISE & b_rise) | (edge_b == `EDGE_FALL & b_fall) |
      (edge_b == `EDGE_BOTH & (b_rise | b_fall));
   wire running = (op_mode != `MODE_STOP); // RL6
   wire tick = running & (presc_reg == `PRESCALE);
   wire wr = psel & penable & pwrite & pready;
   wire rd = psel & ~penable & ~pwrite;
   wire mode_wr = wr & (paddr == `OFF_CTRL);
   wire b_wr = wr & (paddr == `OFF_CCB);
   wire ev_mode = (func == `FUNC_EVENT);
   wire ev_ok = (event_edges_reg == 2'h2); // RL14
   wire cnt_step = ev_mode ? (a_valid & ev_ok) : tick;
   wire match_a = cnt_step & (timer_count_value == compare_capture_reg_a);
   wire match_b = cnt_step & (timer_count_value == compare_capture_reg_b);
   wire os_allowed = (op_mode == `MODE_FREE) | (op_mode == `MODE_CLR_EDGE); // RL9
   wire os_start = (func == `FUNC_ONESHOT) & os_allowed & (soft_trig_reg | a_valid); // RL4
   wire edge_clear = (op_mode == `MODE_CLR_EDGE) & a_valid & ~ev_mode;
   wire cap_a_en = (func == `FUNC_CAPTURE) & ~capture_source_select; // RL11
   wire cap_a_both = capture_source_select & (edge_a == `EDGE_BOTH); // RL10
   wire cap_b = (func == `FUNC_CAPTURE) & a_valid;
   wire [15:0] count_next = (match_a & (op_mode == `MODE_CLR_MATCH | func == `FUNC_PPG))
      ? 16'h0000 : timer_count_value + 16'h0001; // RL1
   always @(posedge clock) begin
      if (rst) begin
         sync_a_reg <= 2'h0;
         sync_b_reg <= 2'h0;
         in_a_reg <= 1'b0;
         in_b_reg <= 1'b0;
      end else begin
         sync_a_reg <= {sync_a_reg[0], trigger_capture_input_a};
         sync_b_reg <= {sync_b_reg[0], capture_input_b};
         in_a_reg <= sync_a_reg[1];
         in_b_reg <= sync_b_reg[1];
      end
   end
   // Count clock divider; restart on any mode write (RL8 one-count skew)
   always @(posedge clock) begin
      if (rst | ~running | mode_wr) begin
         presc_reg <= 4'h0; // RL8
      end else if (presc_reg == `PRESCALE) begin
         presc_reg <= 4'h0;
      end else begin
         presc_reg <= presc_reg + 4'h1;
      end
   end
   // Arming edges for event counting
   always @(posedge clock) begin
      if (rst | ~running | mode_wr) begin
         event_edges_reg <= 2'h0;
      end else if (ev_mode & a_valid & ~ev_ok) begin
         event_edges_reg <= event_edges_reg + 2'h1; // RL14
      end
   end
   // Timer counter
   always @(posedge clock) begin
      if (rst | ~running | mode_wr) begin
         timer_count_value <= 16'h0000;
      end else if (os_start | edge_clear) begin
         timer_count_value <= 16'h0000;
      end else if (cnt_step) begin
         timer_count_value <= count_next;
      end
   end
   // Control register and soft trigger strobe
   always @(posedge clock) begin
      if (rst) begin
         ctrl_reg <= `CTRL_RESET;
         soft_trig_reg <= 1'b0;
      end else begin
         soft_trig_reg <= wr & (paddr == `OFF_TRIG) & pwdata[0];
         if (mode_wr) begin
            ctrl_reg <= pwdata[8:0];
         end
      end
   end
   // Compare/capture register a
   always @(posedge clock) begin
      if (rst) begin
         compare_capture_reg_a <= `CC_RESET;
      end else if (wr & paddr == `OFF_CCA) begin
         compare_capture_reg_a <= pwdata[15:0];
      end else if (cap_a_en & b_valid & ~cap_a_both) begin
         compare_capture_reg_a <= timer_count_value; // RL10
      end
   end
   // Compare/capture register b
   always @(posedge clock) begin
      if (rst) begin
         compare_capture_reg_b <= `CC_RESET;
      end else if (b_wr) begin
         compare_capture_reg_b <= pwdata[15:0];
      end else if (cap_b) begin
         compare_capture_reg_b <= timer_count_value;
      end
   end
   // Overflow flag, set wins over clear
   always @(posedge clock) begin
      if (rst) begin
         ovf_flag_reg <= 1'b0;
      end else if (cnt_step & timer_count_value == 16'hFFFF) begin
         ovf_flag_reg <= 1'b1;
      end else if (wr & paddr == `OFF_STATUS & pwdata[0]) begin
         ovf_flag_reg <= 1'b0;
      end
   end
   // Output waveform and one-shot state
   always @(posedge clock) begin
      if (rst | ~running) begin
         timer_output_pin <= 1'b0;
         oneshot_active_reg <= 1'b0;
      end else begin
         if (b_wr & func == `FUNC_PPG)
            timer_output_pin <= ~timer_output_pin; // RL13
         else if (func == `FUNC_PPG) begin
            if (match_a)
               timer_output_pin <= 1'b1; // RL1
            else if (match_b)
               timer_output_pin <= 1'b0; // RL1
         end else if (func == `FUNC_ONESHOT) begin
            if (os_start)
               oneshot_active_reg <= 1'b1;
            else if (oneshot_active_reg & match_b)
               timer_output_pin <= 1'b1;
            else if (oneshot_active_reg & match_a) begin
               timer_output_pin <= 1'b0;
               oneshot_active_reg <= 1'b0;
            end
         end
      end
   end
   // Match pulses
   always @(posedge clock) begin
      if (rst | ~running) begin
         match_capture_irq_a <= 1'b0;
         match_irq_b <= 1'b0;
      end else begin
         match_capture_irq_a <= match_a | (capture_source_select & b_valid); // RL11
         match_irq_b <= match_b;
      end
   end
   // APB slave, zero wait states
   always @(posedge clock) begin
      if (rst) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & (paddr > `OFF_TRIG | paddr[1:0] != 2'h0);
         if (rd) begin
            case (paddr)
               `OFF_CTRL: prdata <= {23'h000000, ctrl_reg};
               `OFF_CCA: prdata <= {16'h0000, compare_capture_reg_a};
               `OFF_CCB: prdata <= {16'h0000, compare_capture_reg_b};
               `OFF_COUNT: prdata <= {16'h0000, timer_count_value};
               `OFF_STATUS: prdata <= {29'h00000000, oneshot_active_reg, ev_ok, ovf_flag_reg};
               default: prdata <= 32'h00000000;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

//--- tb/timer16_checker_asserts.sv
// Bus and pulse checker for the timer
`timescale 1ns/100ps
`default_nettype none
module timer16_checker (
   input wire clock,
   input wire rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire match_capture_irq_a,
   input wire match_irq_b
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   setup_gets_ready_a: assert property (psel && !penable |=> pready) else $error("no ready");
   ready_one_cycle_a: assert property (pready |=> !pready) else $error("ready too long");
   ready_after_setup_a: assert property (pready |-> $past(psel && !penable))
      else $error("stray ready");
   error_with_ready_a: assert property (pslverr |-> pready) else $error("stray error");
   bad_read_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read not zero");
   read_data_hold_a: assert property (!$past(psel && !penable && !pwrite) |-> $stable(prdata))
      else $error("read data moved");
   irq_a_pulse_a: assert property (match_capture_irq_a |=> !match_capture_irq_a)
      else $error("irq a too long");
   irq_b_pulse_a: assert property (match_irq_b |=> !match_irq_b) else $error("irq b too long");
endmodule
bind timer16_pulse_capture timer16_checker chk (.clock(clock), .rst(rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .match_capture_irq_a(match_capture_irq_a), .match_irq_b(match_irq_b));
`default_nettype wire

//--- tb/timer16_pins.sv
// Drives the external trigger and capture pins
`timescale 1ns/100ps
`default_nettype none
module timer16_pins (
   input wire logic clock,
   output var logic pin_a,
   output var logic pin_b
);
   initial begin
      pin_a = 1'b0;
      pin_b = 1'b0;
   end
   // One high pulse, then a quiet gap before any further edge
   task automatic pulse(input logic sel);
      @(posedge clock);
      if (sel) pin_b <= 1'b1;
      else pin_a <= 1'b1;
      repeat (12) @(posedge clock);
      if (sel) pin_b <= 1'b0;
      else pin_a <= 1'b0;
      repeat (12) @(posedge clock);
   endtask
endmodule
`default_nettype wire

//--- tb/timer16_pulse_capture_tb_top.sv
// Bench for the 16-bit pulse/capture timer
`timescale 1ns/100ps
`default_nettype none
`include "timer16_regs.vh"
module timer16_pulse_capture_tb_top;
   localparam int cnt = `PRESCALE + 1;
   logic clock;
   logic rst;
   logic psel;
   logic penable;
   logic pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] rd;
   logic err;
   wire [31:0] prdata;
   wire pready, pslverr, pin_a, pin_b, out_pin, irq_a, irq_b;
   int errors = 0;
   int samples_checked = 0;
   int irqs = 0;
   int n, hi, lo;
   always #12.5 clock = ~clock;
   always @(posedge clock) if (irq_a === 1'b1) irqs++;
   timer16_pins pins (.clock(clock), .pin_a(pin_a), .pin_b(pin_b));
   timer16_pulse_capture dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .trigger_capture_input_a(pin_a), .capture_input_b(pin_b),
      .timer_output_pin(out_pin), .match_capture_irq_a(irq_a), .match_irq_b(irq_b));
   task automatic stop_test;
      $display("Counts: %0d errors, %0d checked", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(inout int c);
      @(posedge clock);
      c++;
      if (c > 3000) begin
         errors++;
         stop_test();
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      tick(k);
      while (pready !== 1'b1) tick(k);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task automatic wait_pin(input logic lvl, output int c);
      c = 0;
      while (out_pin !== lvl) tick(c);
   endtask
   initial begin
      clock = 1'b0;
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      rdc(`OFF_CTRL, 32'h0);
      rdc(`OFF_CCA, 32'h0000FFFF);
      rdc(`OFF_CCB, 32'h0000FFFF);
      rdc(12'h020, 32'h0);
      chk({31'h0, err}, 32'h1);
      repeat (20) @(posedge clock);
      rdc(`OFF_COUNT, 32'h0);
      apb(1'b1, `OFF_CTRL, 32'h1);
      repeat (40) @(posedge clock);
      apb(1'b0, `OFF_COUNT, 32'h0);
      chk({31'h0, rd > 32'h0}, 32'h1);
      $display("test start done");
      apb(1'b1, `OFF_CTRL, 32'h0);
      apb(1'b1, `OFF_CCA, 32'h9);
      apb(1'b1, `OFF_CCB, 32'h3);
      apb(1'b1, `OFF_CTRL, 32'h7);
      wait_pin(1'b1, n);
      wait_pin(1'b0, n);
      wait_pin(1'b1, n);
      wait_pin(1'b0, hi);
      wait_pin(1'b1, lo);
      chk(32'(hi), 32'((3 + 1) * cnt));
      chk(32'(hi + lo), 32'((9 + 1) * cnt));
      apb(1'b1, `OFF_CCB, 32'h3);
      @(posedge clock);
      chk({31'h0, out_pin}, 32'h0);
      $display("test pulse done");
      apb(1'b1, `OFF_CTRL, 32'h0);
      apb(1'b1, `OFF_CTRL, 32'h2D);
      pins.pulse(1'b0);
      pins.pulse(1'b0);
      rdc(`OFF_COUNT, 32'h0);
      rdc(`OFF_STATUS, 32'h2);
      pins.pulse(1'b0);
      rdc(`OFF_COUNT, 32'h1);
      $display("test event done");
      apb(1'b1, `OFF_CTRL, 32'h0);
      apb(1'b1, `OFF_CCA, 32'h1234);
      apb(1'b1, `OFF_CTRL, 32'hF1);
      n = irqs;
      pins.pulse(1'b1);
      pins.pulse(1'b0);
      chk(32'(irqs - n), 32'h1);
      rdc(`OFF_CCA, 32'h1234);
      $display("test capture done");
      apb(1'b1, `OFF_CTRL, 32'h0);
      apb(1'b1, `OFF_CCA, 32'h20);
      apb(1'b1, `OFF_CCB, 32'h10);
      apb(1'b1, `OFF_CTRL, 32'h29);
      pins.pulse(1'b0);
      wait_pin(1'b1, n);
      wait_pin(1'b0, hi);
      chk(32'(hi), 32'((32'h20 - 32'h10) * cnt));
      apb(1'b1, `OFF_TRIG, 32'h1);
      wait_pin(1'b1, n);
      wait_pin(1'b0, hi);
      chk(32'(hi), 32'((32'h20 - 32'h10) * cnt));
      apb(1'b1, `OFF_CTRL, 32'h2B);
      apb(1'b1, `OFF_TRIG, 32'h1);
      repeat (120) @(posedge clock);
      chk({31'h0, out_pin}, 32'h0);
      $display("test one-shot done");
      stop_test();
   end
endmodule
`default_nettype wire
